//--- rtl/rx_bp_defs.svh
// register offset, field positions, reset value and timing counts
`ifndef RX_BP_DEFS_SVH
`define RX_BP_DEFS_SVH

`define CTL_OFFSET 12'h122
`define CTL_CHAN_MAX 4'h3
`define CTL_RESET 5'h00
`define CTL_FR_BIT 4
`define CTL_INV_BIT 3
`define CTL_MUX_BIT 2
`define RATE_BASE 2'h0
`define HALF_FRAME_TS 5'h0C
`define TS_SER_BITS 3'h5
`define MUX_LAST 2'h3

`endif

//--- rtl/rx_bp_pkg.sv
// types shared by the receive backplane option logic
package rx_bp_pkg;

  typedef struct packed {
    logic fr_en;
    logic clk_inv;
    logic mux_en;
    logic [1:0] rate;
  } ctl_t;

  typedef struct packed {
    logic [4:0] ts_num;
    logic [2:0] bit_idx;
    logic sig;
    logic frac;
    logic rec_clk;
    logic frame;
  } chan_in_t;

endpackage

//--- rtl/rx_backplane_interface_options.sv
// receive backplane option logic: line word fifo and per-channel control
`timescale 1ns/1ps
`include "rx_bp_defs.svh"
// Function
// - control bit 4 enables fractional, signaling, serial id, 8kHz and clock outputs
// - fractional/signaling enable acts only in base-rate mode
// - enable 0 in base rate: id pins show timeslot number in parallel
// - enable 1 in base rate: id pin 0 carries serial signaling
// - enable 1 in base rate: id pin 1 carries fractional data
// - enable 1 in base rate: id pin 2 carries timeslot number serially
// - enable 1 in base rate: id pin 3 carries 8kHz frame clock
// - enable 1 in base rate: id pin 4 carries recovered line clock
// - high-speed or own bit 2 set: pin 0 signaling, pin 4 recovered clock always
// - bit 3 selects data change on rising (0) or falling (1) edge
// - clock inversion works only in base-rate configuration
// - bit 2 set in channel 0's control multiplexes four channels onto one serial output
// - multiplexed backplane runs at 12.352 or 16.384 MHz, partner uses a scaled-down 16 clk_i cycles per phase
// - base-rate mode means rate field 00 (and bit 2 clear in the channel's own control)

// ***********************************
// fifo
// ***********************************
module rx_bp_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic nfull_r;
  logic nempty_r;
  logic push;
  logic pop;

  assign push = in_valid_i & nfull_r;
  assign pop = out_ready_i & nempty_r;
  assign in_ready_o = nfull_r;
  assign out_valid_o = nempty_r;
  assign out_data_o = mem[rptr_r];

  always_comb begin
    count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      nfull_r <= 1'b1;
      nempty_r <= 1'b0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      count_r <= count_nxt;
      // flags kept as flops so ready and valid never glitch
      nfull_r <= (count_nxt != (AW+1)'(DEPTH));
      nempty_r <= (count_nxt != '0);
    end
  end
endmodule

// ***********************************
// top
// ***********************************
module rx_backplane_interface_options (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // line side, one bit per channel
  input wire logic [3:0] line_bits_i,
  input wire logic line_valid_i,
  output logic line_ready_o,
  // framer timing per channel
  input wire rx_bp_pkg::chan_in_t [3:0] chan_i,
  // backplane
  input wire logic rx_serial_clock_i,
  output logic [3:0] rx_serial_data_out_o,
  output logic [3:0][4:0] rx_timeslot_id_pins_o
);

  rx_bp_pkg::ctl_t [3:0] ctl_r;
  logic [3:0] hold_r;
  logic [1:0] sel_r;
  logic sclk_q_r;
  logic [3:0] clk8k_r;
  logic [3:0] edge_w;
  logic [3:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_ready;
  logic sclk_rise, sclk_fall;
  logic mux_on;
  logic wr_hit, rd_hit;
  logic [1:0] chan_sel;

  // ***********************************
  // helpers
  // ***********************************
  function automatic logic is_base(input rx_bp_pkg::ctl_t c);
    is_base = (c.rate == `RATE_BASE) && !c.mux_en;
  endfunction

  function automatic logic hit(input logic [15:0] a);
    hit = (a[11:0] == `CTL_OFFSET) && (a[15:12] <= `CTL_CHAN_MAX);
  endfunction

  function automatic logic ts_serial(input logic [4:0] ts, input logic [2:0] idx);
    logic b;
    b = 1'b0;
    if (idx < `TS_SER_BITS) begin
      b = ts[3'h4 - idx];
    end
    ts_serial = b;
  endfunction

  assign wr_hit = reg_wr_i && hit(reg_addr_i);
  assign rd_hit = reg_rd_i && hit(reg_addr_i);
  assign chan_sel = reg_addr_i[13:12];

  // ***********************************
  // registers
  // ***********************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_r <= {4{`CTL_RESET}};
    end else if (wr_hit) begin
      ctl_r[chan_sel] <= rx_bp_pkg::ctl_t'(reg_wdata_i[4:0]);
    end
  end

  // read data stands for exactly one cycle, unmapped reads give zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (rd_hit) begin
      reg_rdata_o <= {3'h0, ctl_r[chan_sel]};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ***********************************
  // line fifo
  // ***********************************
  rx_bp_fifo #(
    .WIDTH(4),
    .DEPTH(8)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_data_i(line_bits_i),
    .in_valid_i(line_valid_i),
    .in_ready_o(fifo_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // ready is the fifo's own full flop, so it never disagrees with a push
  assign line_ready_o = fifo_ready;

  // ***********************************
  // backplane clock edges
  // ***********************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= rx_serial_clock_i;
    end
  end

  assign sclk_rise = rx_serial_clock_i & ~sclk_q_r;
  assign sclk_fall = ~rx_serial_clock_i & sclk_q_r;
  assign mux_on = ctl_r[0].mux_en;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      edge_w[c] = sclk_rise;
      if (is_base(ctl_r[c]) && ctl_r[c].clk_inv) begin
        edge_w[c] = sclk_fall;
      end
    end
  end

  // partner clocks the multiplexed stream at four times the channel rate
  assign fifo_pop = sclk_rise && (!mux_on || sel_r == `MUX_LAST);

  // ***********************************
  // serial data out
  // ***********************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_r <= 2'h0;
    end else if (!mux_on) begin
      sel_r <= 2'h0;
    end else if (sclk_rise) begin
      sel_r <= sel_r + 2'h1;
    end
  end

  // non-mux words pass through a holding stage so each channel can
  // pick its own edge; an empty fifo sends zeros
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_r <= 4'h0;
    end else if (sclk_rise && !mux_on) begin
      hold_r <= fifo_valid ? fifo_data : 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_serial_data_out_o <= 4'h0;
    end else if (mux_on) begin
      if (sclk_rise) begin
        rx_serial_data_out_o <= {3'h0, fifo_valid & fifo_data[sel_r]};
      end else begin
        rx_serial_data_out_o[3:1] <= 3'h0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (edge_w[c]) begin
          rx_serial_data_out_o[c] <= hold_r[c];
        end
      end
    end
  end

  // ***********************************
  // timeslot identifier pins
  // ***********************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk8k_r <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (chan_i[c].frame) begin
          clk8k_r[c] <= 1'b1;
        end else if (chan_i[c].ts_num == `HALF_FRAME_TS) begin
          clk8k_r[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_timeslot_id_pins_o <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (!is_base(ctl_r[c])) begin
          rx_timeslot_id_pins_o[c] <= {chan_i[c].rec_clk, chan_i[c].ts_num[3:1],
                                       chan_i[c].sig};
        end else if (!ctl_r[c].fr_en) begin
          rx_timeslot_id_pins_o[c] <= chan_i[c].ts_num;
        end else begin
          rx_timeslot_id_pins_o[c] <= {chan_i[c].rec_clk,
                                       clk8k_r[c],
                                       ts_serial(chan_i[c].ts_num, chan_i[c].bit_idx),
                                       chan_i[c].frac,
                                       chan_i[c].sig};
        end
      end
    end
  end

  // ***********************************
  // assertions
  // ***********************************
  wire logic base0 = is_base(ctl_r[0]);

  a_ctl_reset_read: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    reg_rd_i && reg_addr_i == {4'h0, `CTL_OFFSET} |=> reg_rdata_o == {3'h0, $past(ctl_r[0])})
    else $error("control read back wrong");

  a_fr_write: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    reg_wr_i && reg_addr_i == {4'h0, `CTL_OFFSET}
    |=> ctl_r[0].fr_en == $past(reg_wdata_i[`CTL_FR_BIT]))
    else $error("enable bit not stored");

  a_ts_parallel: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    base0 && !ctl_r[0].fr_en |=> rx_timeslot_id_pins_o[0] == $past(chan_i[0].ts_num))
    else $error("parallel timeslot wrong");

  a_sig_frac_pins: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    base0 && ctl_r[0].fr_en |=> rx_timeslot_id_pins_o[0][0] == $past(chan_i[0].sig)
    && rx_timeslot_id_pins_o[0][1] == $past(chan_i[0].frac))
    else $error("signaling or fractional pin wrong");

  a_ts_serial_pin: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    base0 && ctl_r[0].fr_en && chan_i[0].bit_idx == 3'h0
    |=> rx_timeslot_id_pins_o[0][2] == $past(chan_i[0].ts_num[4]))
    else $error("serial timeslot msb wrong");

  a_clk8k_pin: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    base0 && ctl_r[0].fr_en && chan_i[0].frame ##1 base0 && ctl_r[0].fr_en
    |=> rx_timeslot_id_pins_o[0][3])
    else $error("8kHz clock not high after frame");

  a_fast_mode_pins: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !base0 |=> rx_timeslot_id_pins_o[0][4] == $past(chan_i[0].rec_clk)
    && rx_timeslot_id_pins_o[0][0] == $past(chan_i[0].sig))
    else $error("fast mode pins wrong");

  a_edge_select: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !mux_on && $changed(rx_serial_data_out_o[1]) && !$past(mux_on)
    |-> $past(is_base(ctl_r[1]) && ctl_r[1].clk_inv ? sclk_fall : sclk_rise))
    else $error("data changed on wrong edge");

  a_mux_idle: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    mux_on |=> rx_serial_data_out_o[3:1] == 3'h0)
    else $error("muxed mode drives spare outputs");

  a_full_refuse: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    line_ready_o == (u_fifo.count_r != 4'h8))
    else $error("ready disagrees with fifo fill");

  c_fractional: cover property (
    @(posedge clk_i) disable iff (!arst_n_i) base0 && ctl_r[0].fr_en && chan_i[0].frame);
  c_muxed_word: cover property (
    @(posedge clk_i) disable iff (!arst_n_i) mux_on && fifo_pop && fifo_valid);
  c_fifo_full: cover property (
    @(posedge clk_i) disable iff (!arst_n_i) line_valid_i && !fifo_ready);

endmodule

//--- tb/bp_partner.sv
// backplane partner model: bursts of serial clock, samples the data lines
`timescale 1ns/1ps
module bp_partner #(
  // rate scaled down so each phase outlasts the design's clock sync delay
  parameter int HALF = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // burst control
  input wire logic start_i,
  input wire logic [4:0] periods_i,
  output logic busy_o,
  // backplane
  input wire logic [3:0] data_i,
  output logic serial_clk_o
);
  logic [3:0] hi_cap [0:31];
  logic [3:0] lo_cap [0:31];
  int cnt;
  int per;
  // ***********************************
  // clock burst and sampling
  // ***********************************
  // clock stands low between bursts
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_clk_o <= 1'b0;
      busy_o <= 1'b0;
      cnt <= 0;
      per <= 0;
    end else if (!busy_o) begin
      if (start_i) begin
        busy_o <= 1'b1;
        serial_clk_o <= 1'b1;
        cnt <= 0;
        per <= 0;
      end
    end else begin
      // sample late in each phase, once the output has settled
      if (cnt == HALF - 2) begin
        if (serial_clk_o) hi_cap[per] <= data_i;
        else lo_cap[per] <= data_i;
      end
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1 && serial_clk_o) serial_clk_o <= 1'b0;
      else if (cnt == HALF - 1 && per + 1 == int'(periods_i)) busy_o <= 1'b0;
      else if (cnt == HALF - 1) begin
        serial_clk_o <= 1'b1;
        per <= per + 1;
      end
    end
  end
endmodule

//--- tb/test_rx_backplane_interface_options.sv
// testbench for the receive backplane option logic
`timescale 1ns/1ps
module test_rx_backplane_interface_options;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [3:0] line_bits_i = 4'h0;
  logic line_valid_i = 1'b0;
  logic line_ready_o;
  rx_bp_pkg::chan_in_t [3:0] chan_i = '0;
  logic rx_serial_clock_i;
  logic [3:0] rx_serial_data_out_o;
  logic [3:0][4:0] rx_timeslot_id_pins_o;
  logic start = 1'b0;
  logic [4:0] periods = 5'h00;
  logic busy;
  logic [3:0] word;
  logic [7:0] mbit;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  rx_backplane_interface_options rx_backplane_interface_options_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .line_bits_i(line_bits_i), .line_valid_i(line_valid_i), .line_ready_o(line_ready_o),
    .chan_i(chan_i), .rx_serial_clock_i(rx_serial_clock_i),
    .rx_serial_data_out_o(rx_serial_data_out_o), .rx_timeslot_id_pins_o(rx_timeslot_id_pins_o));
  bp_partner bp_partner_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start), .periods_i(periods), .busy_o(busy),
    .data_i(rx_serial_data_out_o), .serial_clk_o(rx_serial_clock_i));
  // ***********************************
  // tasks
  // ***********************************
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    compare("reg_rdata_o", exp, reg_rdata_o);
  endtask
  task automatic push(input logic [3:0] w);
    @(posedge clk_i);
    line_bits_i <= w;
    line_valid_i <= 1'b1;
    do @(posedge clk_i); while (line_ready_o !== 1'b1);
    line_valid_i <= 1'b0;
  endtask
  task automatic run(input logic [4:0] n);
    @(posedge clk_i);
    periods <= n;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    do @(posedge clk_i); while (busy === 1'b1);
    repeat (20) @(posedge clk_i);
  endtask
  task automatic set_chan(input logic [4:0] ts, input logic [2:0] idx, input logic frame);
    @(posedge clk_i);
    for (int c = 0; c < 4; c++) chan_i[c] <= '{ts, idx, 1'b1, 1'b0, 1'b1, frame};
  endtask
  task automatic pins(input logic [3:0][4:0] exp);
    repeat (3) @(posedge clk_i);
    for (int c = 0; c < 4; c++) begin
      compare("id_pins", {3'h0, exp[c]}, {3'h0, rx_timeslot_id_pins_o[c]});
    end
  endtask
  // fifo filled with the serial clock stopped, then drained by the partner
  task automatic fill_run(input logic inv);
    logic [3:0] e;
    for (int i = 1; i <= 8; i++) push(4'(i));
    repeat (3) @(posedge clk_i);
    compare("line_ready_o", 8'h00, {7'h00, line_ready_o});
    run(5'h0A);
    for (int i = 0; i < 10; i++) begin
      e = (i <= 8) ? 4'(i) : 4'h0;
      compare("hi_cap", {4'h0, e}, {4'h0, bp_partner_inst.hi_cap[i]});
      if (inv) e = (i < 8) ? 4'(i + 1) : 4'h0;
      compare("lo_cap", {4'h0, e}, {4'h0, bp_partner_inst.lo_cap[i]});
    end
    compare("line_ready_o", 8'h01, {7'h00, line_ready_o});
  endtask
  // ***********************************
  // sequence
  // ***********************************
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int c = 0; c < 4; c++) rd({4'(c), 12'h122}, 8'h00);
    wr(16'h0123, 8'hFF);
    rd(16'h0123, 8'h00);
    rd(16'h0122, 8'h00);
    wr(16'h3122, 8'hFF);
    rd(16'h3122, 8'h1F);
    wr(16'h3122, 8'h00);
    set_chan(5'h15, 3'h0, 1'b0);
    pins({5'h15, 5'h15, 5'h15, 5'h15});
    wr(16'h1122, 8'h10);
    wr(16'h2122, 8'h11);
    set_chan(5'h15, 3'h0, 1'b1);
    set_chan(5'h15, 3'h0, 1'b0);
    pins({5'h15, 5'h15, 5'h1D, 5'h15});
    set_chan(5'h0C, 3'h5, 1'b0);
    pins({5'h0C, 5'h1D, 5'h11, 5'h0C});
    for (int c = 0; c < 4; c++) wr({4'(c), 12'h122}, 8'h00);
    fill_run(1'b0);
    for (int c = 0; c < 4; c++) wr({4'(c), 12'h122}, 8'h08);
    fill_run(1'b1);
    // second reset after the second run has finished
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(16'h0122, 8'h00);
    wr(16'h0122, 8'h0C);
    push(4'hA);
    push(4'h6);
    run(5'h09);
    for (int k = 0; k < 9; k++) begin
      word = (k < 4) ? 4'hA : 4'h6;
      mbit = (k < 8) ? {7'h00, word[k % 4]} : 8'h00;
      compare("mux_hi", mbit, {4'h0, bp_partner_inst.hi_cap[k]});
      compare("mux_lo", mbit, {4'h0, bp_partner_inst.lo_cap[k]});
    end
    wrap_up();
  end
endmodule
